// >>> hdl/dbgpe_enable_seq.sv
// enable and activation sequencer of the single wire debug port
// Contract
// - once the enable duration ends the port stops driving the data line and lets it float high.
// - if the sync start bit does not come within the start timeout the port disables itself.
// - the start timeout is counted in cycles of the 4 MHz debug clock.
// - a 12V pulse on the reset pin makes it the debug pin whatever the pin function setting is.
// - the rising edge of the high voltage pulse puts the port logic in reset.
// - after tri-stating the port stays in reset until the debugger drives the pin low.
// - after a high voltage enable only power-on reset returns the pin to its default function.
// - the disable bit resets the port and drops its clock request but keeps the debug pin.
`timescale 1ns/100ps
`default_nettype none
module dbgpe_enable_seq #(
  parameter int EN_DRIVE_TICKS = dbgpe_pkg::EN_DRIVE_TICKS_DEF,
  parameter int SYNC_TMO_TICKS = dbgpe_pkg::SYNC_TMO_TICKS_DEF,
  parameter int CNT_W = dbgpe_pkg::CNT_W_DEF
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire dbgpe_pkg::dbgpe_pins_t pins_in,
  input wire logic reset_pin_function_cfg_in,
  input wire logic debug_port_disable_bit_in,
  output logic line_o_out,
  output logic line_oe_out,
  output dbgpe_pkg::dbgpe_stat_t stat_out,
  output logic [CNT_W-4:0] bit_period_out
);
  import dbgpe_pkg::*;

  localparam int TICK_GAP = TICK_CYC;

  dbgpe_state_t state_r;
  dbgpe_state_t state_nxt;
  logic [TICK_W-1:0] div_r;
  logic [TMR_W-1:0] tmr_r;
  logic hv_prev_r;
  logic pin_prev_r;
  logic rx_prev_r;
  logic hv_en_r;
  logic sync_ok_r;
  logic tick;
  logic hv_rise;
  logic pin_fall;
  logic rx_fall;
  logic clk_req;
  logic pin_debug;
  logic drive_end;
  logic tmo_end;
  logic meter_done;
  logic meter_err;

  // --------------------------------------------------------------
  // edges and debug clock tick
  // --------------------------------------------------------------
  // edges of synchronous pin levels
  assign hv_rise = pins_in.hv_det & ~hv_prev_r;
  assign pin_fall = ~pins_in.rst_lvl & pin_prev_r;
  assign rx_fall = ~pins_in.rx & rx_prev_r;
  assign clk_req = (state_r != ST_OFF) && (state_r != ST_HV_RST);
  assign pin_debug = reset_pin_function_cfg_in | hv_en_r;
  assign tick = clk_req && (div_r == TICK_W'(TICK_CYC - 1));
  assign drive_end = tick && (tmr_r == TMR_W'(EN_DRIVE_TICKS - 1));
  assign tmo_end = tick && (tmr_r == TMR_W'(SYNC_TMO_TICKS - 1));

  // previous pin levels
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hv_prev_r <= 1'b0;
      pin_prev_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      hv_prev_r <= pins_in.hv_det;
      pin_prev_r <= pins_in.rst_lvl;
      rx_prev_r <= pins_in.rx;
    end
  end

  // debug clock divider, runs only while the clock is requested
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_r <= '0;
    end else if (!clk_req || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // tick timer, restarts on every state change
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r) begin
      tmr_r <= '0;
    end else if (tick) begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  // --------------------------------------------------------------
  // high voltage enable flag
  // --------------------------------------------------------------
  // sticky until power-on reset only
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hv_en_r <= 1'b0;
    end else if (hv_rise) begin
      hv_en_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  // next state, pulse edge first, then disable
  always_comb begin
    state_nxt = state_r;
    if (hv_rise) begin
      state_nxt = ST_HV_RST;
    end else if (debug_port_disable_bit_in) begin
      state_nxt = ST_OFF;
    end else begin
      case (state_r)
        ST_OFF: begin
          if (pin_debug && pin_fall) begin
            state_nxt = ST_DRIVE;
          end
        end
        ST_HV_RST: begin
          if (!pins_in.hv_det && pin_fall) begin
            state_nxt = ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          if (drive_end) begin
            state_nxt = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (rx_fall) begin
            state_nxt = ST_SYNC;
          end else if (tmo_end) begin
            state_nxt = ST_OFF;
          end
        end
        ST_SYNC: begin
          if (meter_done) begin
            state_nxt = ST_READY;
          end else if (meter_err) begin
            state_nxt = ST_OFF;
          end
        end
        ST_READY: begin
          state_nxt = ST_READY;
        end
        default: begin
          state_nxt = ST_OFF;
        end
      endcase
    end
  end

  // state and sync flag
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ST_OFF;
      sync_ok_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sync_ok_r <= (state_nxt == ST_READY);
    end
  end

  // bit period meter for the sync character
  dbgpe_sync_meter #(
    .CNT_W(CNT_W)
  ) u_meter (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .start_in(rx_fall && state_r == ST_WAIT),
    .abort_in(state_r != ST_SYNC),
    .fall_in(rx_fall),
    .done_out(meter_done),
    .err_out(meter_err),
    .period_out(bit_period_out)
  );

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // line held low only while driving, else released to the pull-up
  assign line_o_out = 1'b0;
  assign line_oe_out = (state_r == ST_DRIVE);
  // one driver for the whole status word: active, pin_debug, clk_req, sync_ok
  assign stat_out = {(state_r == ST_READY), pin_debug, clk_req, sync_ok_r};

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  property p_release;
    state_r == ST_DRIVE && drive_end && !hv_rise && !debug_port_disable_bit_in
    |=> !line_oe_out && state_r == ST_WAIT;
  endproperty
  a_release: assert property (p_release) else $error("line not released");

  property p_timeout;
    state_r == ST_WAIT && tmo_end && !rx_fall && !hv_rise && !debug_port_disable_bit_in
    |=> state_r == ST_OFF && !clk_req;
  endproperty
  a_timeout: assert property (p_timeout) else $error("start timeout missed");

  property p_tick;
    state_r == ST_WAIT && tick && state_nxt == ST_WAIT
    |-> ##1 !tick ##(TICK_GAP - 1) tick || state_r != ST_WAIT;
  endproperty
  a_tick: assert property (p_tick) else $error("debug tick spacing wrong");

  property p_hv_pin;
    hv_rise |=> pin_debug && hv_en_r;
  endproperty
  a_hv_pin: assert property (p_hv_pin) else $error("pin not switched");

  property p_hv_reset;
    hv_rise |=> state_r == ST_HV_RST && !clk_req && !line_oe_out;
  endproperty
  a_hv_reset: assert property (p_hv_reset) else $error("pulse did not reset");

  property p_hv_hold;
    state_r == ST_HV_RST && !(pin_fall && !pins_in.hv_det) && !debug_port_disable_bit_in
    |=> state_r == ST_HV_RST;
  endproperty
  a_hv_hold: assert property (p_hv_hold) else $error("left reset early");

  property p_hv_sticky;
    hv_en_r |=> hv_en_r;
  endproperty
  a_hv_sticky: assert property (p_hv_sticky) else $error("debug pin lost");

  property p_disable;
    debug_port_disable_bit_in && !hv_rise
    |=> state_r == ST_OFF && !clk_req && pin_debug == $past(pin_debug);
  endproperty
  a_disable: assert property (p_disable) else $error("disable failed");

  c_hv_ready: cover property (hv_en_r && $rose(stat_out.active));
  c_fuse_ready: cover property (!hv_en_r && $rose(stat_out.active));
  c_timeout: cover property (state_r == ST_WAIT && tmo_end);
  c_disable: cover property (state_r == ST_READY && debug_port_disable_bit_in);

endmodule : dbgpe_enable_seq
`default_nettype wire

// >>> common/dbgpe_pkg.sv
// shared constants and types for the debug port enable sequencer
`default_nettype none
package dbgpe_pkg;

  // --------------------------------------------------------------
  // clocks and time bases
  // --------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 200000; // system clock rate
  localparam int DBG_CLK_KHZ = 4000; // debug port clock rate
  localparam int TICK_CYC = SYS_CLK_KHZ / DBG_CLK_KHZ; // sys cycles per debug tick
  localparam int TICK_W = 6;
  localparam int TMR_W = 16;

  // --------------------------------------------------------------
  // sequence lengths, in debug clock ticks
  // --------------------------------------------------------------
  localparam int EN_DRIVE_TICKS_DEF = 16; // line held low after wake
  localparam int SYNC_TMO_TICKS_DEF = 4096; // start bit wait limit

  // --------------------------------------------------------------
  // sync character measurement
  // --------------------------------------------------------------
  localparam logic [7:0] SYNC_CHAR = 8'h55; // alternating bits, lsb first
  localparam logic [2:0] SYNC_LAST_EDGE = 3'h3; // falls after start, minus one
  localparam int BIT_SHIFT = 3; // eight bit times between first and last fall
  localparam int CNT_W_DEF = 16;

  // --------------------------------------------------------------
  // sequencer states, one-hot
  // --------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_HV_RST = 6'h02,
    ST_DRIVE = 6'h04,
    ST_WAIT = 6'h08,
    ST_SYNC = 6'h10,
    ST_READY = 6'h20
  } dbgpe_state_t;

  // pin levels seen by the sequencer
  typedef struct packed {
    logic rst_lvl; // reset pin logic level
    logic hv_det; // high voltage detected on reset pin
    logic rx; // data line level
  } dbgpe_pins_t;

  // status levels shown to the rest of the chip
  typedef struct packed {
    logic active; // port ready for frames
    logic pin_debug; // reset pin works as debug port
    logic clk_req; // debug clock requested
    logic sync_ok; // sync character measured
  } dbgpe_stat_t;

endpackage : dbgpe_pkg
`default_nettype wire

// >>> hdl/dbgpe_sync_meter.sv
// sync character bit period meter
`timescale 1ns/100ps
`default_nettype none
module dbgpe_sync_meter #(
  parameter int CNT_W = dbgpe_pkg::CNT_W_DEF
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic fall_in,
  output logic done_out,
  output logic err_out,
  output logic [CNT_W-4:0] period_out
);
  import dbgpe_pkg::*;

  logic busy_r;
  logic done_r;
  logic err_r;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0] edges_r;
  logic [CNT_W-4:0] period_r;

  // --------------------------------------------------------------
  // measurement
  // --------------------------------------------------------------
  // count cycles from start bit fall to the fall of the last zero bit
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      cnt_r <= '0;
      edges_r <= 3'h0;
      period_r <= '0;
    end else begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      if (start_in) begin
        busy_r <= 1'b1;
        cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
        edges_r <= 3'h0;
      end else if (abort_in) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 1'b1;
        if (fall_in && edges_r == SYNC_LAST_EDGE) begin
          busy_r <= 1'b0; // eight bit times seen
          done_r <= 1'b1;
          period_r <= cnt_r[CNT_W-1:BIT_SHIFT];
        end else if (&cnt_r) begin
          busy_r <= 1'b0; // too slow to be a sync character
          err_r <= 1'b1;
        end else if (fall_in) begin
          edges_r <= edges_r + 3'h1;
        end
      end
    end
  end

  assign done_out = done_r;
  assign err_out = err_r;
  assign period_out = period_r;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_period;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    busy_r && !start_in && !abort_in && fall_in && edges_r == SYNC_LAST_EDGE
    |=> done_out && period_out == $past(cnt_r[CNT_W-1:BIT_SHIFT]);
  endproperty
  a_period: assert property (p_period) else $error("bit period not taken");

endmodule : dbgpe_sync_meter
`default_nettype wire

// >>> tb/dbgpe_dbg_model.sv
// external debugger model on the reset pin and data line
`timescale 1ns/100ps
`default_nettype none
module dbgpe_dbg_model (
  input wire logic clk_sys_in,
  input wire logic line_o_in,
  input wire logic line_oe_in,
  output dbgpe_pkg::dbgpe_pins_t pins_out,
  output logic late_out
);
  import dbgpe_pkg::*;
  logic late_r = 1'b0;
  logic rst_r = 1'b1;
  logic hv_r = 1'b0;
  logic rx_r = 1'b1;
  // device drive wins; a released line is pulled high
  assign pins_out = {rst_r, hv_r, line_oe_in ? line_o_in : rx_r};
  // sticky flag: the line never went high before a sync character
  assign late_out = late_r;

  // drive reset pin level and high voltage together
  task automatic put(input logic rst, input logic hv);
    @(posedge clk_sys_in);
    rst_r <= rst;
    hv_r <= hv;
  endtask : put

  // sync character, lsb first, once the line is high or after 2000 cycles of waiting; no frames follow
  task automatic send_sync(input int p);
    logic [9:0] fr;
    fr = {1'b1, SYNC_CHAR, 1'b0};
    for (int k = 0; k < 2000 && (line_oe_in || !pins_out.rx); k++) begin
      @(posedge clk_sys_in);
    end
    if (line_oe_in || !pins_out.rx) begin
      late_r <= 1'b1;
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys_in);
      rx_r <= fr[i];
      repeat (p - 1) @(posedge clk_sys_in);
    end
  endtask : send_sync
endmodule : dbgpe_dbg_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench of the debug port enable sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dbgpe_pkg::*;
  localparam int EN_T = 2;
  localparam int TMO_T = 8;
  logic clk_sys_in;
  logic rstn_in;
  logic cfg_r;
  logic dis_r;
  dbgpe_pins_t pins;
  logic line_o;
  logic line_oe;
  dbgpe_stat_t stat;
  logic [12:0] bit_period;
  logic sync_late;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  int p;
  int plist[3];

  dbgpe_enable_seq #(.EN_DRIVE_TICKS(EN_T), .SYNC_TMO_TICKS(TMO_T), .CNT_W(16))
    i_dbgpe_enable_seq (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .pins_in(pins),
    .reset_pin_function_cfg_in(cfg_r), .debug_port_disable_bit_in(dis_r),
    .line_o_out(line_o), .line_oe_out(line_oe), .stat_out(stat),
    .bit_period_out(bit_period));
  dbgpe_dbg_model i_dbgpe_dbg_model (.clk_sys_in(clk_sys_in), .line_o_in(line_o),
    .line_oe_in(line_oe), .pins_out(pins), .late_out(sync_late));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [12:0] exp_period(input int q);
    return 13'((8 * q) >> BIT_SHIFT);
  endfunction : exp_period

  function automatic logic sel(input int w);
    return w == 0 ? line_oe : (w == 1 ? stat.clk_req : stat.active);
  endfunction : sel

  task automatic tally_and_finish();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_val(input string nm, input logic [12:0] e, input logic [12:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_val

  task automatic step(input int c);
    repeat (c) @(posedge clk_sys_in);
    #1;
  endtask : step

  // bounded wait for a status level, counting cycles
  task automatic wait_for(input int w, input logic v, output int cnt);
    cnt = 0;
    while (sel(w) !== v && cnt < 3000) begin
      step(1);
      cnt++;
    end
    if (sel(w) !== v) begin
      err_count++;
      $display("mismatch wait_for %0d expected %b seen %b", w, v, sel(w));
      tally_and_finish();
    end
  endtask : wait_for

  // wake by low drive, then count the drive length
  task automatic wake_and_drive();
    i_dbgpe_dbg_model.put(1'b0, 1'b0);
    step(1);
    chk_bit("line_oe", 1'b1, line_oe);
    chk_bit("clk_req", 1'b1, stat.clk_req);
    chk_bit("line_o", 1'b0, line_o);
    wait_for(0, 1'b0, n);
    chk_val("drive_len", 13'(EN_T * TICK_CYC), 13'(n));
    chk_bit("rx", 1'b1, pins.rx);
    i_dbgpe_dbg_model.put(1'b1, 1'b0);
    #1;
  endtask : wake_and_drive

  task automatic disable_port();
    @(posedge clk_sys_in);
    dis_r <= 1'b1;
    @(posedge clk_sys_in);
    dis_r <= 1'b0;
    step(1);
    chk_bit("clk_req", 1'b0, stat.clk_req);
    chk_bit("active", 1'b0, stat.active);
  endtask : disable_port

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn_in = 1'b0;
    cfg_r = 1'b0;
    dis_r = 1'b0;
    void'($urandom(32'hbcb2));
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    step(1);
    chk_bit("line_oe", 1'b0, line_oe);
    chk_bit("pin_debug", 1'b0, stat.pin_debug);
    // low drive refused while the pin is not the debug pin
    i_dbgpe_dbg_model.put(1'b0, 1'b0);
    step(3);
    chk_bit("line_oe", 1'b0, line_oe);
    i_dbgpe_dbg_model.put(1'b1, 1'b0);
    cfg_r <= 1'b1;
    // no start bit: port gives up after the start timeout
    wake_and_drive();
    wait_for(1, 1'b0, n);
    chk_bit("tmo_len", 1'b1, n >= TMO_T * TICK_CYC - 5 && n <= TMO_T * TICK_CYC + 5);
    i_dbgpe_dbg_model.send_sync(20);
    step(4);
    chk_bit("active", 1'b0, stat.active);
    // repeated enable with short, random and long bit periods
    plist = '{8, 16 + int'($urandom % 64), 1000};
    foreach (plist[i]) begin
      p = plist[i];
      disable_port();
      wake_and_drive();
      i_dbgpe_dbg_model.send_sync(p);
      wait_for(2, 1'b1, n);
      chk_bit("sync_ok", 1'b1, stat.sync_ok);
      chk_val("bit_period", exp_period(p), bit_period);
    end
    // high voltage rise resets an active port whatever the pin setting
    cfg_r <= 1'b0;
    i_dbgpe_dbg_model.put(1'b1, 1'b1);
    step(1);
    chk_bit("active", 1'b0, stat.active);
    chk_bit("clk_req", 1'b0, stat.clk_req);
    chk_bit("pin_debug", 1'b1, stat.pin_debug);
    i_dbgpe_dbg_model.put(1'b0, 1'b1);
    step(20000);
    chk_bit("line_oe", 1'b0, line_oe);
    i_dbgpe_dbg_model.put(1'b1, 1'b0);
    step(60);
    chk_bit("clk_req", 1'b0, stat.clk_req);
    wake_and_drive();
    i_dbgpe_dbg_model.send_sync(24);
    wait_for(2, 1'b1, n);
    chk_val("bit_period", exp_period(24), bit_period);
    disable_port();
    chk_bit("pin_debug", 1'b1, stat.pin_debug);
    rstn_in <= 1'b0;
    step(2);
    rstn_in <= 1'b1;
    step(2);
    chk_bit("pin_debug", 1'b0, stat.pin_debug);
    // device freshly reset, then a high voltage pulse held for 20000 cycles
    i_dbgpe_dbg_model.put(1'b1, 1'b1);
    step(20000);
    chk_bit("pin_debug", 1'b1, stat.pin_debug);
    chk_bit("clk_req", 1'b0, stat.clk_req);
    i_dbgpe_dbg_model.put(1'b1, 1'b0);
    step(4);
    chk_bit("clk_req", 1'b0, stat.clk_req);
    chk_bit("sync_wait", 1'b0, sync_late);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
